//--- hw/eeprom_write_defs.svh
// Purpose: constants for the two-wire EEPROM write path
// Assumes: included by bare name, definitions only
`ifndef EEPROM_WRITE_DEFS_SVH
`define EEPROM_WRITE_DEFS_SVH

`define BITS_PER_BYTE 4'h8
`define BYTE_IDX_CTRL 2'h0
`define BYTE_IDX_ADDR 2'h1
`define BYTE_IDX_DATA 2'h2
`define CTRL_RW_BIT 0
`define CTRL_CODE_MSB 7
`define CTRL_CODE_LSB 4
`define PAGE_LO_W 3
`define PAGE_SIZE 8
`define ADDR_W 8
`define WR_CYCLES_DFLT 1000
// Arbitrary device code value
`define DEV_CODE_DFLT 4'hA

`endif

//--- hw/eeprom_write_pkg.sv
// Purpose: shared types for the two-wire EEPROM write path
// Assumes: nothing
// Notes: constants live in eeprom_write_defs.svh
package eeprom_write_pkg;
    typedef logic [7:0] byte_t;
    typedef enum {WR_IDLE, WR_PROG} wr_state_t;
endpackage

//--- hw/link_byte_rx.sv
// Purpose: bit receiver and acknowledge driver on the link clock
// Assumes: master changes data only while the link clock is low
// Notes: frame reset comes from the core domain on every START and STOP
`timescale 1ns/10ps
`include "eeprom_write_defs.svh"
module link_byte_rx
    import eeprom_write_pkg::*;
#(
    parameter logic [3:0] DEV_CODE = `DEV_CODE_DFLT
) (
    // Resets
    input wire logic rst,
    input wire logic link_rst,
    // Link clock and data pin
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // From core domain
    input wire logic busy_async,
    // Accepted byte toward core domain
    output byte_t byte_r,
    output logic [1:0] byte_kind_r,
    output logic byte_tgl_r
);
    logic [3:0] bit_cnt_r;
    byte_t shift_r;
    logic [1:0] idx_r;
    logic sel_r;
    logic busy_s1_r;
    logic busy_s2_r;
    logic ack_ok;

    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            busy_s1_r <= 1'b0;
            busy_s2_r <= 1'b0;
        end else begin
            busy_s1_r <= busy_async;
            busy_s2_r <= busy_s1_r;
        end
    end

    always_ff @(posedge scl_clk or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
        end else if (bit_cnt_r == `BITS_PER_BYTE) begin
            bit_cnt_r <= 4'h0;
        end else begin
            shift_r <= {shift_r[6:0], sda_in};
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // Read commands and foreign codes get no acknowledge
    always_comb begin
        if (idx_r == `BYTE_IDX_CTRL) begin
            ack_ok = (shift_r[`CTRL_CODE_MSB:`CTRL_CODE_LSB] == DEV_CODE) &&
                     !shift_r[`CTRL_RW_BIT] && !busy_s2_r;
        end else begin
            ack_ok = sel_r && !busy_s2_r;
        end
    end

    // Driven on the falling edge so data never moves while the clock is high
    always_ff @(negedge scl_clk or posedge link_rst) begin
        if (link_rst) begin
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            sda_oe <= (bit_cnt_r == `BITS_PER_BYTE) && ack_ok;
            sda_out <= 1'b0;
        end
    end

    always_ff @(posedge scl_clk or posedge link_rst) begin
        if (link_rst) begin
            idx_r <= `BYTE_IDX_CTRL;
            sel_r <= 1'b0;
        end else if (bit_cnt_r == `BITS_PER_BYTE && sda_oe) begin
            if (idx_r == `BYTE_IDX_CTRL) begin
                sel_r <= 1'b1;
            end
            if (idx_r != `BYTE_IDX_DATA) begin
                idx_r <= idx_r + 2'h1;
            end
        end
    end

    // Toggle only resets with the system reset, else a frame reset looks like an event
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            byte_r <= 8'h00;
            byte_kind_r <= `BYTE_IDX_CTRL;
            byte_tgl_r <= 1'b0;
        end else if (bit_cnt_r == `BITS_PER_BYTE && sda_oe && !link_rst) begin
            byte_r <= shift_r;
            byte_kind_r <= idx_r;
            byte_tgl_r <= !byte_tgl_r;
        end
    end

    default clocking cb @(posedge scl_clk); endclocking
    default disable iff (link_rst);

    busy_no_ack_a: assert property (
        busy_s2_r && bit_cnt_r == `BITS_PER_BYTE |-> !sda_oe)
        else $error("acknowledge given while programming");
    ctrl_ack_a: assert property (
        bit_cnt_r == `BITS_PER_BYTE && idx_r == `BYTE_IDX_CTRL && !busy_s2_r &&
        shift_r[`CTRL_CODE_MSB:`CTRL_CODE_LSB] == DEV_CODE && !shift_r[`CTRL_RW_BIT]
        |-> sda_oe)
        else $error("write control byte not acknowledged");
    read_no_ack_a: assert property (
        bit_cnt_r == `BITS_PER_BYTE && idx_r == `BYTE_IDX_CTRL && shift_r[`CTRL_RW_BIT]
        |-> !sda_oe)
        else $error("read control byte acknowledged");
    ack_slot_a: assert property (
        sda_oe |-> bit_cnt_r == `BITS_PER_BYTE)
        else $error("acknowledge outside ninth clock");
    byte_pass_a: assert property (
        bit_cnt_r == `BITS_PER_BYTE && sda_oe |=> byte_tgl_r != $past(byte_tgl_r))
        else $error("acknowledged byte not handed over");
endmodule

//--- hw/eeprom_write_core.sv
// Purpose: write side of a two-wire serial data EEPROM with page buffer
// Assumes: START and STOP are held long enough to be seen through synchronisers
// Notes: byte reception runs on the link clock in link_byte_rx
`timescale 1ns/10ps
`include "eeprom_write_defs.svh"
module eeprom_write_core
    import eeprom_write_pkg::*;
#(
    parameter int WRITE_CYCLES = `WR_CYCLES_DFLT,
    parameter logic [3:0] DEV_CODE = `DEV_CODE_DFLT,
    parameter int DEPTH = 256
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Two-wire link
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Memory read port
    input wire logic [`ADDR_W-1:0] rd_addr,
    output byte_t rd_data,
    // Status
    output logic busy
);
    localparam int CNT_W = (WRITE_CYCLES > 1) ? $clog2(WRITE_CYCLES) : 1;

    logic scl_s1_r, scl_s2_r, scl_s3_r;
    logic sda_s1_r, sda_s2_r, sda_s3_r;
    logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
    logic start_det, stop_det, byte_evt, commit;
    logic link_rst_r;
    byte_t link_byte;
    logic [1:0] link_kind;
    logic link_tgl;
    logic [`ADDR_W-1:0] ptr_r;
    byte_t page_r [`PAGE_SIZE];
    logic [`PAGE_SIZE-1:0] valid_r;
    wr_state_t state_r;
    logic [CNT_W-1:0] wr_cnt_r;
    byte_t mem_r [DEPTH];

    // Low bits wrap inside the page, high bits hold
    function automatic logic [`ADDR_W-1:0] next_ptr(input logic [`ADDR_W-1:0] p);
        next_ptr = {p[`ADDR_W-1:`PAGE_LO_W], p[`PAGE_LO_W-1:0] + 3'h1};
    endfunction

    link_byte_rx #(.DEV_CODE(DEV_CODE)) u_rx (
        .rst(rst),
        .link_rst(link_rst_r),
        .scl_clk(scl),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .busy_async(busy),
        .byte_r(link_byte),
        .byte_kind_r(link_kind),
        .byte_tgl_r(link_tgl)
    );

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_s3_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_s3_r <= 1'b1;
        end else begin
            scl_s1_r <= scl;
            scl_s2_r <= scl_s1_r;
            scl_s3_r <= scl_s2_r;
            sda_s1_r <= sda_in;
            sda_s2_r <= sda_s1_r;
            sda_s3_r <= sda_s2_r;
        end
    end

    // Event crossing: link data is stable for a whole byte after the toggle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_s3_r <= 1'b0;
        end else begin
            tgl_s1_r <= link_tgl;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
        end
    end

    assign start_det = scl_s2_r && scl_s3_r && sda_s3_r && !sda_s2_r;
    assign stop_det = scl_s2_r && scl_s3_r && !sda_s3_r && sda_s2_r;
    assign byte_evt = tgl_s2_r ^ tgl_s3_r;
    assign commit = (state_r == WR_PROG) && (wr_cnt_r == '0);

    // Held from START until clock first goes low; held idle after STOP
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            link_rst_r <= 1'b1;
        end else if (start_det || stop_det) begin
            link_rst_r <= 1'b1;
        end else if (!scl_s2_r) begin
            link_rst_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ptr_r <= 8'h00;
        end else if (byte_evt && link_kind == `BYTE_IDX_ADDR) begin
            ptr_r <= link_byte;
        end else if (byte_evt && link_kind == `BYTE_IDX_DATA) begin
            ptr_r <= next_ptr(ptr_r);
        end
    end

    // A fresh address drops anything not yet committed
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            valid_r <= '0;
            for (int i = 0; i < `PAGE_SIZE; i++) begin
                page_r[i] <= 8'h00;
            end
        end else if (commit || (byte_evt && link_kind == `BYTE_IDX_ADDR)) begin
            valid_r <= '0;
        end else if (byte_evt && link_kind == `BYTE_IDX_DATA) begin
            page_r[ptr_r[`PAGE_LO_W-1:0]] <= link_byte;
            valid_r[ptr_r[`PAGE_LO_W-1:0]] <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= WR_IDLE;
            wr_cnt_r <= '0;
            busy <= 1'b0;
        end else begin
            unique case (state_r)
                WR_IDLE: begin
                    if (stop_det && |valid_r) begin
                        state_r <= WR_PROG;
                        wr_cnt_r <= CNT_W'(WRITE_CYCLES - 1);
                        busy <= 1'b1;
                    end
                end
                WR_PROG: begin
                    if (commit) begin
                        state_r <= WR_IDLE;
                        busy <= 1'b0;
                    end else begin
                        wr_cnt_r <= wr_cnt_r - 1'b1;
                    end
                end
            endcase
        end
    end

    // Array is volatile here; contents after reset are zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= 8'h00;
            end
        end else if (commit) begin
            for (int i = 0; i < `PAGE_SIZE; i++) begin
                if (valid_r[i]) begin
                    mem_r[{ptr_r[`ADDR_W-1:`PAGE_LO_W], 3'(i)}] <= page_r[i];
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem_r[rd_addr];
        end
    end

    default clocking cs @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence data_taken_s;
        byte_evt && link_kind == `BYTE_IDX_DATA;
    endsequence

    start_frame_a: assert property (
        start_det |=> link_rst_r)
        else $error("frame not reset on START");
    stop_prog_a: assert property (
        stop_det && |valid_r && state_r == WR_IDLE |=> busy && state_r == WR_PROG)
        else $error("STOP did not start programming");
    ptr_step_a: assert property (
        data_taken_s |=> ptr_r[`ADDR_W-1:`PAGE_LO_W] == $past(ptr_r[`ADDR_W-1:`PAGE_LO_W])
        && ptr_r[`PAGE_LO_W-1:0] == $past(ptr_r[`PAGE_LO_W-1:0]) + 3'h1)
        else $error("pointer step wrong");
    page_fill_a: assert property (
        data_taken_s |=> valid_r[$past(ptr_r[`PAGE_LO_W-1:0])] &&
        page_r[$past(ptr_r[`PAGE_LO_W-1:0])] == $past(link_byte))
        else $error("page buffer not written");
    addr_load_a: assert property (
        byte_evt && link_kind == `BYTE_IDX_ADDR |=> ptr_r == $past(link_byte))
        else $error("address pointer not loaded");
    commit_late_a: assert property (
        state_r == WR_PROG && wr_cnt_r != '0 |=> state_r == WR_PROG && busy && |valid_r)
        else $error("programming ended early");
    cycle_end_a: assert property (
        commit |=> !busy && state_r == WR_IDLE && valid_r == '0)
        else $error("busy not released after programming");
    // A STOP must also close the frame, or a stray byte could follow it
    stop_frame_a: assert property (
        stop_det |=> link_rst_r)
        else $error("frame not reset on STOP");
    // Polls end in a STOP with nothing buffered; that must not restart the cycle
    empty_stop_a: assert property (
        stop_det && valid_r == '0 && state_r == WR_IDLE |=> state_r == WR_IDLE && !busy)
        else $error("programming started without data");
endmodule

//--- verification/twowire_master.sv
// Purpose: bit-banged two-wire bus master that stands in for the processor
// Assumes: the data wire has a pull-up; sda is its resolved level
// Notes: link clock has a 125 ns period and stands high outside frames
`timescale 1ns/10ps
module twowire_master (
    // Link clock and open-drain data
    output logic scl,
    output logic sda_drv,
    // Resolved data wire
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Long setup and hold so the device's synchronisers see the edge
    task automatic frame_start();
        sda_drv = 1'b1;
        #62.5 scl = 1'b1;
        #200 sda_drv = 1'b0;
        #200 scl = 1'b0;
        // Clock held low until the device has let go of its frame reset
        #200;
    endtask

    task automatic frame_stop();
        scl = 1'b0;
        sda_drv = 1'b0;
        #62.5 scl = 1'b1;
        #200 sda_drv = 1'b1;
        #200;
    endtask

    // Data only changes while the clock is low; ninth clock for acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            scl = 1'b0;
            #31.25 sda_drv = b[i];
            #31.25 scl = 1'b1;
            #62.5;
        end
        scl = 1'b0;
        #31.25 sda_drv = 1'b1;
        #31.25 scl = 1'b1;
        #31.25 ack = ~sda;
        #31.25;
    endtask
endmodule

//--- verification/serial_eeprom_write_ack_poll_test.sv
// Purpose: self-checking bench for the EEPROM write and acknowledge-poll path
// Assumes: shortened programming cycle so polling sees refusals quickly
// Notes: byte writes run from a table; page wrap and refusals are hand-written
`timescale 1ns/10ps
`include "eeprom_write_defs.svh"
module serial_eeprom_write_ack_poll_test
    import eeprom_write_pkg::*;
;
    typedef struct {byte_t addr; byte_t ctrl; byte_t data;} row_t;
    localparam int WCYC = 200;
    localparam byte_t CTRL = {`DEV_CODE_DFLT, 4'h0};
    logic sys_clk;
    logic rst;
    logic [7:0] rd_addr;
    byte_t rd_data;
    logic busy;
    logic sda_out;
    logic sda_oe;
    logic scl;
    logic sda_drv;
    wire logic sda_w;
    int fails;
    int checks;
    int polls;
    int j;
    logic ack;
    byte_t wbuf [10];
    row_t rows [3] = '{'{8'h00, CTRL, 8'h5A}, '{8'h37, CTRL | 8'h0E, 8'hC3},
        '{8'hFF, CTRL | 8'h04, 8'h01}};

    assign sda_w = (sda_oe ? sda_out : 1'b1) & sda_drv;
    always #25 sys_clk = ~sys_clk;

    eeprom_write_core #(.WRITE_CYCLES(WCYC), .DEV_CODE(`DEV_CODE_DFLT), .DEPTH(256)) uut (
        .sys_clk(sys_clk), .rst(rst), .scl(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy));
    twowire_master mst (.scl(scl), .sda_drv(sda_drv), .sda(sda_w));

    task automatic tally_and_finish();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk_byte(input byte_t got, input byte_t exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic put(input byte_t b, input logic exp);
        mst.send_byte(b, ack);
        chk_bit(ack, exp);
    endtask

    // Frame left open so the caller can look before the STOP
    task automatic write_page(input byte_t ctl, input byte_t a, input int n);
        mst.frame_start();
        put(ctl, 1'b1);
        put(a, 1'b1);
        for (int i = 0; i < n; i++) put(wbuf[i], 1'b1);
    endtask

    // Repeated START on every refusal, bounded so a stuck device cannot hang
    task automatic poll(output int n);
        n = 0;
        mst.frame_start();
        mst.send_byte(CTRL, ack);
        while (ack !== 1'b1 && n < 60) begin
            n++;
            mst.frame_start();
            mst.send_byte(CTRL, ack);
        end
        chk_bit(ack, 1'b1);
        mst.frame_stop();
    endtask

    task automatic rd(input byte_t a, input byte_t exp);
        @(posedge sys_clk) rd_addr <= a;
        repeat (2) @(posedge sys_clk);
        #1 chk_byte(rd_data, exp);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        tally_and_finish();
    end

    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        rd_addr = 8'h00;
        repeat (11) @(posedge sys_clk);
        #1 chk_bit(busy, 1'b0);
        chk_bit(sda_oe, 1'b0);
        @(posedge sys_clk) rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        foreach (rows[i]) begin
            wbuf[0] = rows[i].data;
            write_page(rows[i].ctrl, rows[i].addr, 1);
            mst.frame_stop();
            poll(polls);
            chk_bit(logic'(polls > 0), 1'b1);
            rd(rows[i].addr, rows[i].data);
        end
        // Ten bytes from offset 5: the last two land on offsets 5 and 6 again
        for (int i = 0; i < 10; i++) wbuf[i] = 8'h10 + i[7:0];
        write_page(CTRL, 8'h45, 10);
        rd(8'h45, 8'h00);
        mst.frame_stop();
        repeat (6) @(posedge sys_clk);
        #1 chk_bit(busy, 1'b1);
        poll(polls);
        for (int o = 0; o < 8; o++) begin
            j = (o + 3) % 8;
            if (j < 2) j += 8;
            rd({5'h08, o[2:0]}, 8'h10 + j[7:0]);
        end
        rd(8'h48, 8'h00);
        mst.frame_start();
        put(8'h50, 1'b0);
        put(8'h20, 1'b0);
        mst.frame_stop();
        mst.frame_start();
        put(CTRL | 8'h01, 1'b0);
        mst.frame_stop();
        repeat (6) @(posedge sys_clk);
        #1 chk_bit(busy, 1'b0);
        // Reset in mid-programming drops the cycle; the next poll is taken at once
        write_page(CTRL, 8'h62, 1);
        mst.frame_stop();
        repeat (6) @(posedge sys_clk);
        #1 chk_bit(busy, 1'b1);
        @(posedge sys_clk) rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk_bit(busy, 1'b0);
        chk_bit(sda_oe, 1'b0);
        @(posedge sys_clk) rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        poll(polls);
        chk_byte(8'(polls), 8'h00);
        rd(8'h62, 8'h00);
        tally_and_finish();
    end
endmodule
